// ### design/rhd_defines.vh
`ifndef RHD_DEFINES_VH
`define RHD_DEFINES_VH

// Register offsets within the host controller operational space.
`define RHD_DESC_A_OFFSET 8'h48
`define RHD_DESC_B_OFFSET 8'h4c

// Descriptor A field positions.
`define RHD_PGWAIT_MSB 31
`define RHD_PGWAIT_LSB 24
`define RHD_NO_OC_BIT 12
`define RHD_OC_MODE_BIT 11
`define RHD_COMPOUND_BIT 10
`define RHD_ALWAYS_PWR_BIT 9
`define RHD_SW_MODE_BIT 8
`define RHD_PORT_CNT_MSB 7
`define RHD_PORT_CNT_LSB 0

// Descriptor A reset values.
`define RHD_PGWAIT_RESET 8'hff
`define RHD_NO_OC_RESET 1'b0
`define RHD_ALWAYS_PWR_RESET 1'b0
`define RHD_SW_MODE_RESET 1'b1
`define RHD_PORT_CNT_VALUE 8'h01

// Descriptor B field positions and reset values.
`define RHD_MASK_MSB 31
`define RHD_MASK_LSB 16
`define RHD_REMOV_MSB 15
`define RHD_REMOV_LSB 0
`define RHD_MASK_RESET 16'h0002
`define RHD_REMOV_RESET 16'h0000

// Number of physical downstream ports with power control.
`define RHD_NUM_PORTS 1

// Power-on to power-good time unit.
`define RHD_PGWAIT_UNIT_MS 2

`endif

// ### design/rhd_root_hub_descriptor_a_reg.v
// Rules from the document behind this block
// [R1] Driver waits power-good field (bits 31:24) times 2 ms before touching a powered port.
// [R2] Bit 12 set means no overcurrent protection; clear means mode bit selects reporting.
// [R3] Bit 11 selects collective (0) or per-port (1) overcurrent reporting, valid when bit 12 clear.
// [R4] Reset loads the overcurrent reporting mode bit with the power switch mode value.
// [R5] Bit 10 is read-only and always reads zero.
// [R6] Bit 9 clear means ports are switched; set means always powered.
// [R7] Bit 8 clear powers all ports together; valid only when bit 9 clear.
// [R8] In per-port mode, masked ports follow port commands, unmasked ports follow global ones.
// [R9] Bits 7:0 are a read-only port count, between 1 and 15.
// [R10] Software writes reserved bits 23:13 as zero.
// [R11] Port power control mask lives in descriptor B bits 31:16; bit 0 reserved.
`timescale 1ns/10ps
`include "rhd_defines.vh"

module rhd_root_hub_descriptor_a_reg (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_wdata_i,
    input wire global_power_on_cmd_i,
    input wire global_power_off_cmd_i,
    input wire [`RHD_NUM_PORTS:1] per_port_power_on_cmd_i,
    input wire [`RHD_NUM_PORTS:1] per_port_power_off_cmd_i,
    output reg [31:0] reg_rdata_o,
    output reg [`RHD_NUM_PORTS:1] port_power_o,
    output reg oc_protect_absent_o,
    output reg oc_per_port_o,
    output reg [7:0] power_good_wait_time_o
);

    // Stored fields of descriptor A.
    reg [7:0] power_good_wait_time_ff;
    reg no_overcurrent_protect_ff;
    reg overcurrent_report_mode_ff;
    reg always_powered_flag_ff;
    reg power_switch_mode_ff;

    // Stored fields of descriptor B.
    reg [15:0] port_power_control_mask_ff;
    reg [15:0] device_removable_ff;

    // Next values of the stored fields.
    reg [7:0] nxt_power_good_wait_time;
    reg nxt_no_overcurrent_protect;
    reg nxt_overcurrent_report_mode;
    reg nxt_always_powered_flag;
    reg nxt_power_switch_mode;
    reg [15:0] nxt_port_power_control_mask;
    reg [15:0] nxt_device_removable;

    // Next values of the registered outputs.
    reg [31:0] nxt_rdata;
    reg nxt_oc_per_port;
    wire [`RHD_NUM_PORTS:1] nxt_port_power;

    // Assembled register images and decoded strobes.
    wire compound_device_flag;
    wire [31:0] desc_a_value;
    wire [31:0] desc_b_value;
    wire sel_a;
    wire sel_b;
    wire wr_a;
    wire wr_b;

    // The offset compare is shared by the write strobes and the read mux.
    function addr_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    assign compound_device_flag = 1'b0; // [R5]

    assign sel_a = addr_hit(reg_addr_i, `RHD_DESC_A_OFFSET);
    assign sel_b = addr_hit(reg_addr_i, `RHD_DESC_B_OFFSET);
    assign wr_a = reg_wr_i && sel_a;
    assign wr_b = reg_wr_i && sel_b;

    // Reserved bits 23:13 are not stored, so they read back as zero whatever is written.
    assign desc_a_value = {power_good_wait_time_ff, 11'h000, no_overcurrent_protect_ff, // [R10]
                           overcurrent_report_mode_ff, compound_device_flag,
                           always_powered_flag_ff, power_switch_mode_ff,
                           `RHD_PORT_CNT_VALUE}; // [R9]
    assign desc_b_value = {port_power_control_mask_ff, device_removable_ff};

    // Descriptor A next values; the port count and the compound flag have no storage.
    always @* begin
        nxt_power_good_wait_time = power_good_wait_time_ff;
        nxt_no_overcurrent_protect = no_overcurrent_protect_ff;
        nxt_overcurrent_report_mode = overcurrent_report_mode_ff;
        nxt_always_powered_flag = always_powered_flag_ff;
        nxt_power_switch_mode = power_switch_mode_ff;
        if (wr_a) begin
            nxt_power_good_wait_time = reg_wdata_i[`RHD_PGWAIT_MSB:`RHD_PGWAIT_LSB]; // [R1]
            nxt_no_overcurrent_protect = reg_wdata_i[`RHD_NO_OC_BIT]; // [R2]
            nxt_overcurrent_report_mode = reg_wdata_i[`RHD_OC_MODE_BIT]; // [R3]
            nxt_always_powered_flag = reg_wdata_i[`RHD_ALWAYS_PWR_BIT]; // [R6]
            nxt_power_switch_mode = reg_wdata_i[`RHD_SW_MODE_BIT]; // [R7]
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_good_wait_time_ff <= `RHD_PGWAIT_RESET; // [R1]
        end else begin
            power_good_wait_time_ff <= nxt_power_good_wait_time;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            no_overcurrent_protect_ff <= `RHD_NO_OC_RESET;
        end else begin
            no_overcurrent_protect_ff <= nxt_no_overcurrent_protect;
        end
    end

    // Reporting style starts out matching the switching style.
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            overcurrent_report_mode_ff <= `RHD_SW_MODE_RESET; // [R4]
        end else begin
            overcurrent_report_mode_ff <= nxt_overcurrent_report_mode;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            always_powered_flag_ff <= `RHD_ALWAYS_PWR_RESET;
        end else begin
            always_powered_flag_ff <= nxt_always_powered_flag;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_switch_mode_ff <= `RHD_SW_MODE_RESET;
        end else begin
            power_switch_mode_ff <= nxt_power_switch_mode;
        end
    end

    // Descriptor B next values. Mask bit 0 has no port behind it and stays zero.
    always @* begin
        nxt_port_power_control_mask = port_power_control_mask_ff;
        nxt_device_removable = device_removable_ff;
        if (wr_b) begin
            nxt_port_power_control_mask = {reg_wdata_i[`RHD_MASK_MSB:`RHD_MASK_LSB + 1], 1'b0}; // [R11]
            nxt_device_removable = reg_wdata_i[`RHD_REMOV_MSB:`RHD_REMOV_LSB];
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_power_control_mask_ff <= `RHD_MASK_RESET; // [R11]
        end else begin
            port_power_control_mask_ff <= nxt_port_power_control_mask;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            device_removable_ff <= `RHD_REMOV_RESET;
        end else begin
            device_removable_ff <= nxt_device_removable;
        end
    end

    // Per-port power switching. Unless always powered, on and off from the same source together leave the port off, the safe choice.
    genvar p;
    generate
        for (p = 1; p <= `RHD_NUM_PORTS; p = p + 1) begin : g_port
            reg nxt_power;
            always @* begin
                nxt_power = port_power_o[p];
                if (always_powered_flag_ff) begin
                    nxt_power = 1'b1; // [R6]
                end else if (power_switch_mode_ff && port_power_control_mask_ff[p]) begin
                    if (per_port_power_off_cmd_i[p]) begin // [R8]
                        nxt_power = 1'b0;
                    end else if (per_port_power_on_cmd_i[p]) begin
                        nxt_power = 1'b1;
                    end
                end else begin
                    if (global_power_off_cmd_i) begin // [R7]
                        nxt_power = 1'b0;
                    end else if (global_power_on_cmd_i) begin
                        nxt_power = 1'b1;
                    end
                end
            end
            assign nxt_port_power[p] = nxt_power;
        end
    endgenerate

    // Unmapped offsets read as zero rather than aliasing a register.
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (sel_a) begin
            nxt_rdata = desc_a_value;
        end else if (sel_b) begin
            nxt_rdata = desc_b_value;
        end
    end

    // The mode bit only has meaning while protection is present.
    always @* begin
        nxt_oc_per_port = !no_overcurrent_protect_ff && overcurrent_report_mode_ff; // [R3]
    end

    // Read data holds between strobes so software may sample it late.
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_power_o <= {`RHD_NUM_PORTS{1'b0}};
        end else begin
            port_power_o <= nxt_port_power;
        end
    end

    // The wait time is only reported; enforcing it is left to the driver.
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oc_protect_absent_o <= 1'b0;
            oc_per_port_o <= 1'b0;
            power_good_wait_time_o <= 8'h00;
        end else begin
            oc_protect_absent_o <= no_overcurrent_protect_ff; // [R2]
            oc_per_port_o <= nxt_oc_per_port;
            power_good_wait_time_o <= power_good_wait_time_ff;
        end
    end

endmodule

// ### testbench/rhd_desc_checker.sv
`timescale 1ns/10ps
module rhd_desc_checker (
    input wire sys_clk_i, arst_n_i, reg_wr_i, reg_rd_i, global_power_on_cmd_i, global_power_off_cmd_i,
    input wire [7:0] reg_addr_i, power_good_wait_time_o,
    input wire [31:0] reg_wdata_i, reg_rdata_o,
    input wire [1:1] per_port_power_on_cmd_i, per_port_power_off_cmd_i, port_power_o,
    input wire oc_protect_absent_o, oc_per_port_o
);
    reg [31:0] a_ff, b_ff;
    wire wa = reg_wr_i && reg_addr_i == 8'h48;
    wire ra = reg_rd_i && reg_addr_i == 8'h48;
    wire on_g = global_power_on_cmd_i && !global_power_off_cmd_i && !per_port_power_off_cmd_i && !a_ff[9];
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            a_ff <= 32'hff000901;
            b_ff <= 32'h00020000;
        end else if (wa) a_ff <= reg_wdata_i;
        else if (reg_wr_i && reg_addr_i == 8'h4c) b_ff <= reg_wdata_i;
    end
    oc_absent_a: assert property (wa |=> ##1 oc_protect_absent_o == $past(reg_wdata_i[12], 2))
        else $error("absent flag wrong");
    oc_mode_a: assert property (wa |=> ##1 oc_per_port_o == (!$past(reg_wdata_i[12], 2) && $past(reg_wdata_i[11], 2)))
        else $error("report mode wrong");
    wait_copy_a: assert property (wa |=> ##1 power_good_wait_time_o == $past(reg_wdata_i[31:24], 2))
        else $error("wait time wrong");
    dt_zero_a: assert property (ra |=> !reg_rdata_o[10]) else $error("device type not zero");
    port_count_a: assert property (ra |=> reg_rdata_o[7:0] == 8'h01) else $error("port count wrong");
    always_on_a: assert property (wa && reg_wdata_i[9] |=> ##1 port_power_o == 1'b1) else $error("not powered");
    gang_on_a: assert property (on_g && !(a_ff[8] && b_ff[17]) |=> port_power_o == 1'b1)
        else $error("global on ignored");
    mask_hold_a: assert property (on_g && a_ff[8] && b_ff[17] && !per_port_power_on_cmd_i |=> $stable(port_power_o))
        else $error("masked port obeyed global");
    b_bit0_a: assert property (reg_rd_i && reg_addr_i == 8'h4c |=> !reg_rdata_o[16]) else $error("mask bit0 set");
endmodule
bind rhd_root_hub_descriptor_a_reg rhd_desc_checker u_chk (.*);

// ### testbench/tb.sv
`timescale 1ns/10ps
module tb;
    reg sys_clk_i = 1'b0, arst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    reg global_power_on_cmd_i = 1'b0, global_power_off_cmd_i = 1'b0;
    reg [1:1] per_port_power_on_cmd_i = 1'b0, per_port_power_off_cmd_i = 1'b0;
    reg [7:0] reg_addr_i = 8'h00;
    reg [31:0] reg_wdata_i = 32'h0;
    wire [31:0] reg_rdata_o;
    wire [1:1] port_power_o;
    wire oc_protect_absent_o, oc_per_port_o;
    wire [7:0] power_good_wait_time_o;
    integer n_fail = 0, check_count = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    rhd_root_hub_descriptor_a_reg DUT (.*);
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge sys_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge sys_clk_i) reg_wr_i <= 1'b0;
        @(posedge sys_clk_i) #1;
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        @(posedge sys_clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge sys_clk_i) reg_rd_i <= 1'b0;
        #1 chk("read data", exp, reg_rdata_o);
    endtask
    // Command bits are global on, global off, port on, port off; outputs are checked one edge later.
    task cmd(input [3:0] c, input [10:0] exp);
        @(posedge sys_clk_i) {global_power_on_cmd_i, global_power_off_cmd_i, per_port_power_on_cmd_i,
            per_port_power_off_cmd_i} <= c;
        @(posedge sys_clk_i) {global_power_on_cmd_i, global_power_off_cmd_i, per_port_power_on_cmd_i,
            per_port_power_off_cmd_i} <= 4'h0;
        #1 chk("outputs", {21'h0, exp}, {21'h0, port_power_o, oc_protect_absent_o, oc_per_port_o,
            power_good_wait_time_o});
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        rd(8'h48, 32'hff000901);
        rd(8'h4c, 32'h00020000);
        cmd(4'h0, 11'h1ff);
        $display("test reset done");
        wr(8'h48, 32'hff001fff);
        rd(8'h48, 32'hff001b01);
        cmd(4'h4, 11'h6ff);
        wr(8'h48, 32'h12000800);
        cmd(4'h4, 11'h112);
        cmd(4'h8, 11'h512);
        $display("test ganged done");
        wr(8'h48, 32'h00000100);
        cmd(4'h4, 11'h400);
        cmd(4'h1, 11'h000);
        cmd(4'h8, 11'h000);
        cmd(4'h2, 11'h400);
        wr(8'h4c, 32'h0001ffff);
        rd(8'h4c, 32'h0000ffff);
        cmd(4'h4, 11'h000);
        cmd(4'h2, 11'h000);
        rd(8'h40, 32'h0);
        $display("test per-port done");
        finish_test;
    end
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        n_fail = n_fail + 1;
        finish_test;
    end
endmodule
